// [eas_pkg.sv]
// Constants and types for the serial EEPROM bus front end
package eas_pkg;
   // Clock rate of clk_sys_i
   localparam int unsigned CLK_MHZ           = 125;
   localparam int unsigned CLK_PERIOD_NS     = 8;
   // Input spike filter width, 400 kHz grade, in ns
   localparam int unsigned SPIKE_FILTER_NS   = 50;
   // Spike filter in cycles, rounded up
   localparam int unsigned SPIKE_FILTER_CYC  =
      (SPIKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FILT_W            = 4;
   // Programming cycle, longest time in ms, standard part
   localparam int unsigned PROG_CYCLE_MS     = 10;
   // Programming cycle in cycles, exact product
   localparam int unsigned PROG_CYCLE_CYC    = PROG_CYCLE_MS * 1000 * CLK_MHZ;
   localparam int unsigned PROG_W            = 21;
   // Fixed device type code of an EEPROM
   localparam logic [3:0]  DEV_TYPE_CODE     = 4'ha;
   // Slave address field positions
   localparam int unsigned TYPE_MSB          = 7;
   localparam int unsigned TYPE_LSB          = 4;
   localparam int unsigned SEL_HIGH_POS      = 3;
   localparam int unsigned SEL_LOW_POS       = 2;
   localparam int unsigned PAGE_SEL_POS      = 1;
   localparam int unsigned RW_POS            = 0;
   // Read/write bit values
   localparam logic        RW_READ           = 1'b1;
   localparam logic        RW_WRITE          = 1'b0;
   // Bits per byte, the acknowledge clock follows
   localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;

   // Bus front end states
   typedef enum logic [6:0]
   {
      ST_IDLE = 7'h01,   // Waiting for START
      ST_SLV  = 7'h02,   // Shifting slave address
      ST_ACK  = 7'h04,   // Driving acknowledge
      ST_ADDR = 7'h08,   // Shifting array address
      ST_DATA = 7'h10,   // Shifting write data
      ST_READ = 7'h20,   // Read transfer, data supplied elsewhere
      ST_PROG = 7'h40    // Self-timed programming, bus ignored
   } eas_state_t;
endpackage : eas_pkg

// [eas_slave.sv]
// Two-wire serial EEPROM slave front end: framing, addressing, write cycle
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// RL1 - During programming, bus disabled, SDA released, own address not acknowledged.
// RL2 - Programming starts at STOP closing a write; lasts at most 10 ms.
// RL3 - Pulses on SCL and SDA narrower than filter width are ignored.
// RL4 - Select pins act as chip select; address must match strapped levels.
// RL5 - Master opens every transaction with START and sends following bytes.
// RL6 - Addressed receiver acknowledges each byte to continue the transfer.
// RL7 - Master normally ends every transaction with a STOP.
// RL8 - Master sends type, select, rw bit, then array address after acknowledge.
// RL9 - Slave address decodes as 4-bit type, 3-bit select, 1-bit rw.
// RL10 - Mismatch in type or select bits: no acknowledge, idle until START.
// RL11 - Final address bit one means read, zero means write.
// RL12 - Receiver pulls SDA low on ninth clock, then releases it.
// RL13 - Byte after acknowledged slave address is the eight-bit array address.
// RL14 - Select bit without a pin chooses the page block internally.
module eas_slave
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   sys_rst_i,
   input  wire logic                   scl_i,
   input  wire logic                   sda_i,
   output logic                        sda_o,
   output logic                        sda_oe_o,
   input  wire logic                   chip_select_pin_high_i,
   input  wire logic                   chip_select_pin_low_i,
   output logic                        wr_valid_o,
   input  wire logic                   wr_ready_i,
   output logic [8:0]                  wr_addr_o,
   output logic [7:0]                  wr_data_o,
   output logic                        rd_req_o,
   output logic [8:0]                  cur_addr_o,
   output logic                        prog_busy_o
);
   import eas_pkg::*;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Synchronisers, spike filter and edge detection

   logic [1:0]        scl_sync_reg, scl_sync_next;
   logic [1:0]        sda_sync_reg, sda_sync_next;
   logic [1:0]        pin_sync0_reg, pin_sync0_next;
   logic [1:0]        pin_sync1_reg, pin_sync1_next;
   logic              scl_f_reg, scl_f_next, sda_f_reg, sda_f_next;
   logic [FILT_W-1:0] scl_cnt_reg, scl_cnt_next, sda_cnt_reg, sda_cnt_next;
   logic              scl_rise, scl_fall, start_det, stop_det;

   // A level must hold for the full filter width before it is believed
   always_comb
   begin
      scl_sync_next  = {scl_sync_reg[0], scl_i};
      sda_sync_next  = {sda_sync_reg[0], sda_i};
      pin_sync0_next = {chip_select_pin_high_i, chip_select_pin_low_i};
      pin_sync1_next = pin_sync0_reg;
      scl_f_next     = scl_f_reg;
      sda_f_next     = sda_f_reg;
      scl_cnt_next   = '0;
      sda_cnt_next   = '0;
      if (scl_sync_reg[1] != scl_f_reg)
      begin
         scl_cnt_next = scl_cnt_reg + 1'b1;
         if (scl_cnt_reg == FILT_W'(SPIKE_FILTER_CYC - 1))  // see RL3
         begin
            scl_f_next   = scl_sync_reg[1];
            scl_cnt_next = '0;
         end
      end
      if (sda_sync_reg[1] != sda_f_reg)
      begin
         sda_cnt_next = sda_cnt_reg + 1'b1;
         if (sda_cnt_reg == FILT_W'(SPIKE_FILTER_CYC - 1))  // see RL3
         begin
            sda_f_next   = sda_sync_reg[1];
            sda_cnt_next = '0;
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (sys_rst_i)
      begin
         scl_sync_reg  <= 2'h3;
         sda_sync_reg  <= 2'h3;
         pin_sync0_reg <= 2'h0;
         pin_sync1_reg <= 2'h0;
         scl_f_reg     <= 1'b1;
         sda_f_reg     <= 1'b1;
         scl_cnt_reg   <= '0;
         sda_cnt_reg   <= '0;
      end
      else
      begin
         scl_sync_reg  <= scl_sync_next;
         sda_sync_reg  <= sda_sync_next;
         pin_sync0_reg <= pin_sync0_next;
         pin_sync1_reg <= pin_sync1_next;
         scl_f_reg     <= scl_f_next;
         sda_f_reg     <= sda_f_next;
         scl_cnt_reg   <= scl_cnt_next;
         sda_cnt_reg   <= sda_cnt_next;
      end
   end

   // SDA moving while SCL is high marks START or STOP
   assign scl_rise  = scl_f_next & ~scl_f_reg;
   assign scl_fall  = ~scl_f_next & scl_f_reg;
   assign start_det = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
   assign stop_det  = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Protocol engine

   eas_state_t        st_reg, st_next, after_ack_reg, after_ack_next;
   logic [7:0]        shift_reg, shift_next;
   logic [3:0]        bit_reg, bit_next;
   logic              page_reg, page_next;
   logic [7:0]        addr_reg, addr_next;
   logic              wrote_reg, wrote_next;
   logic              ack_seen_reg, ack_seen_next;
   logic [PROG_W-1:0] prog_reg, prog_next;
   logic              match;
   logic [7:0]        byte_in;
   // Two-entry write buffer
   logic [16:0]       buf_mem [2];
   logic [16:0]       buf_wdata;
   logic              buf_wr;
   logic [1:0]        buf_cnt_reg, buf_cnt_next;
   logic              buf_wp_reg, buf_wp_next, buf_rp_reg, buf_rp_next;

   assign byte_in = {shift_reg[6:0], sda_f_reg};
   // Judged on the finished byte held in shift_reg at the eighth falling edge
   assign match = (shift_reg[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE)          // see RL9
                & (shift_reg[SEL_HIGH_POS] == pin_sync1_reg[1])            // see RL4
                & (shift_reg[SEL_LOW_POS] == pin_sync1_reg[0]);            // see RL4

   always_comb
   begin
      st_next        = st_reg;
      after_ack_next = after_ack_reg;
      shift_next     = shift_reg;
      bit_next       = bit_reg;
      page_next      = page_reg;
      addr_next      = addr_reg;
      wrote_next     = wrote_reg;
      ack_seen_next  = ack_seen_reg;
      prog_next      = prog_reg;
      buf_wr         = 1'b0;
      buf_wdata      = {page_reg, addr_reg, shift_reg};
      if (st_reg == ST_PROG)
      begin
         // Bus ignored entirely until the write cycle expires
         prog_next = prog_reg - 1'b1;                                      // see RL1
         if (prog_reg == '0)                                               // see RL2
            st_next = ST_IDLE;
      end
      else if (stop_det)
      begin
         st_next = wrote_reg ? ST_PROG : ST_IDLE;                          // see RL2
         prog_next  = PROG_W'(PROG_CYCLE_CYC - 1);
         wrote_next = 1'b0;
      end
      else if (start_det)
      begin
         // Repeated START also lands here, aborting a half byte
         st_next    = ST_SLV;
         bit_next   = '0;
         wrote_next = 1'b0;
      end
      else
      begin
         unique case (st_reg)
            ST_IDLE, ST_READ :
               st_next = st_reg;                                           // see RL10
            ST_SLV, ST_ADDR, ST_DATA :
               if (scl_rise)
               begin
                  shift_next = byte_in;
                  bit_next   = bit_reg + 1'b1;
               end
               else if (scl_fall && bit_reg == BITS_PER_BYTE)
               begin
                  bit_next = '0;
                  st_next  = ST_ACK;                                       // see RL12
                  if (st_reg == ST_SLV)
                  begin
                     // A foreign address must not move our page or pointer
                     if (match)
                     begin
                        page_next      = shift_reg[PAGE_SEL_POS];          // see RL14
                        after_ack_next = ST_ADDR;
                        if (shift_reg[RW_POS] == RW_READ)                  // see RL11
                           after_ack_next = ST_READ;
                     end
                     else
                        st_next = ST_IDLE;                                 // see RL10
                  end
                  else if (st_reg == ST_ADDR)
                  begin
                     addr_next      = shift_reg;                           // see RL13
                     after_ack_next = ST_DATA;
                  end
                  else if (buf_cnt_reg != 2'h2)
                  begin
                     buf_wr         = 1'b1;
                     addr_next      = addr_reg + 1'b1;
                     wrote_next     = 1'b1;
                     after_ack_next = ST_DATA;
                  end
                  else
                     st_next = ST_IDLE;                  // Buffer full, byte refused
               end
            ST_ACK :
               if (scl_rise)
                  ack_seen_next = 1'b1;
               else if (scl_fall && ack_seen_reg)
               begin
                  ack_seen_next = 1'b0;
                  st_next       = after_ack_reg;                           // see RL6
               end
            default :
               st_next = ST_IDLE;
         endcase
      end
   end

   // Buffer pointers; drain side stalls on wr_ready_i
   always_comb
   begin
      buf_wp_next  = buf_wp_reg ^ buf_wr;
      buf_rp_next  = buf_rp_reg ^ (wr_valid_o & wr_ready_i);
      buf_cnt_next = buf_cnt_reg + {1'b0, buf_wr} - {1'b0, wr_valid_o & wr_ready_i};
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (buf_wr)
         buf_mem[buf_wp_reg] <= buf_wdata;
      if (sys_rst_i)
      begin
         st_reg        <= ST_IDLE;
         after_ack_reg <= ST_IDLE;
         shift_reg     <= '0;
         bit_reg       <= '0;
         page_reg      <= 1'b0;
         addr_reg      <= '0;
         wrote_reg     <= 1'b0;
         ack_seen_reg  <= 1'b0;
         prog_reg      <= '0;
         buf_cnt_reg   <= '0;
         buf_wp_reg    <= 1'b0;
         buf_rp_reg    <= 1'b0;
         sda_oe_o      <= 1'b0;
      end
      else
      begin
         st_reg        <= st_next;
         after_ack_reg <= after_ack_next;
         shift_reg     <= shift_next;
         bit_reg       <= bit_next;
         page_reg      <= page_next;
         addr_reg      <= addr_next;
         wrote_reg     <= wrote_next;
         ack_seen_reg  <= ack_seen_next;
         prog_reg      <= prog_next;
         buf_cnt_reg   <= buf_cnt_next;
         buf_wp_reg    <= buf_wp_next;
         buf_rp_reg    <= buf_rp_next;
         sda_oe_o      <= (st_next == ST_ACK);                             // see RL12
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open drain: only ever pull low, never during programming
   assign sda_o       = 1'b0;                                              // see RL1
   assign wr_valid_o  = (buf_cnt_reg != 2'h0);
   assign wr_addr_o   = buf_mem[buf_rp_reg][16:8];
   assign wr_data_o   = buf_mem[buf_rp_reg][7:0];
   assign rd_req_o    = (st_reg == ST_READ);
   assign cur_addr_o  = {page_reg, addr_reg};
   assign prog_busy_o = (st_reg == ST_PROG);

endmodule : eas_slave

// [eas_asserts.sv]
// Port-level checks on the EEPROM bus front end
`timescale 1ns/1ps
module eas_asserts
(
   input wire logic       clk_sys_i,
   input wire logic       sys_rst_i,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic       chip_select_pin_high_i,
   input wire logic       chip_select_pin_low_i,
   input wire logic       wr_valid_o,
   input wire logic       wr_ready_i,
   input wire logic [8:0] wr_addr_o,
   input wire logic [7:0] wr_data_o,
   input wire logic       rd_req_o,
   input wire logic [8:0] cur_addr_o,
   input wire logic       prog_busy_o
);
   import eas_pkg::*;
   logic [PROG_W-1:0] busy_cnt_reg;
   logic [PROG_W-1:0] busy_cnt_next;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   //////////////////////////////////////////////////////////
   // Length of the running programming cycle; a stuck busy shows here
   always_comb busy_cnt_next = prog_busy_o ? busy_cnt_reg + 1'b1 : '0;
   always_ff @(posedge clk_sys_i) busy_cnt_reg <= sys_rst_i ? '0 : busy_cnt_next;
   // Acknowledge shape and timing
   a_ack_pull_low: assert property (sda_oe_o |-> !sda_o)
      else $error("ack enable without low drive");
   a_ack_min_hold: assert property ($rose(sda_oe_o) |=> sda_oe_o[*8])
      else $error("ack dropped too early");
   a_ack_released: assert property (sda_oe_o |-> ##[1:300] !sda_oe_o)
      else $error("ack never released");
   // Quiet bus side while programming, entry at STOP, bounded length
   a_busy_no_ack: assert property (prog_busy_o |-> !sda_oe_o)
      else $error("ack while programming");
   a_busy_no_read: assert property (prog_busy_o |-> !rd_req_o)
      else $error("read request while programming");
   a_prog_at_stop: assert property ($rose(prog_busy_o) |-> scl_i && sda_i)
      else $error("programming began without stop");
   a_prog_bound: assert property (busy_cnt_reg <= PROG_CYCLE_CYC)
      else $error("programming cycle too long");
   // A stalled word must not change under the consumer
   a_buf_hold: assert property (wr_valid_o && !wr_ready_i |=>
      wr_valid_o && $stable(wr_data_o) && $stable(wr_addr_o))
      else $error("buffered word lost or changed");
endmodule : eas_asserts
bind eas_slave eas_asserts i_chk (.*);

// [eas_master.sv]
// Behavioural two-wire bus master for the EEPROM front end
`timescale 1ns/1ps
module eas_master
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Clock idles high and stands still between frames; sda_o high means released
   initial scl_o = 1'b1;
   initial sda_o = 1'b1;
   //////////////////////////////////////////////////////////
   // Quarter of the 160 ns link period; data moves mid-low, clear of the filter lag
   task automatic qp;
      repeat (5) @(posedge clk_i);
      #1;
   endtask : qp
   // One clock pulse carrying one data bit
   task automatic clk_bit(input logic b);
      qp();
      sda_o = b;
      qp();
      scl_o = 1'b1;
      qp();
      qp();
      scl_o = 1'b0;
   endtask : clk_bit
   // Data falls while clock high
   task automatic start_cond;
      sda_o = 1'b0;
      qp();
      qp();
      scl_o = 1'b0;
   endtask : start_cond
   // Data rises while clock high, then the bus rests
   task automatic stop_cond;
      qp();
      sda_o = 1'b0;
      qp();
      scl_o = 1'b1;
      qp();
      qp();
      sda_o = 1'b1;
      qp();
      qp();
   endtask : stop_cond
   // Clock pulse far narrower than the filter width, inside a low phase
   task automatic scl_spike;
      scl_o = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      scl_o = 1'b0;
      qp();
   endtask : scl_spike
   // MSB first, then release for the ninth clock and read the answer
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i]);
      qp();
      sda_o = 1'b1;
      qp();
      scl_o = 1'b1;
      qp();
      qp();
      ack = !sda_i;
      scl_o = 1'b0;
      qp();
      qp();
   endtask : send_byte
endmodule : eas_master

// [eas_slave_bench.sv]
// Self-checking bench for the EEPROM bus front end
`timescale 1ns/1ps
module eas_slave_bench;
   import eas_pkg::*;
   logic       clk_sys_i, sys_rst_i, scl, m_sda, sda_i, sda_o, sda_oe_o, ack;
   logic       pin_hi, pin_lo, wr_valid_o, wr_ready_i, rd_req_o, prog_busy_o;
   logic [8:0] wr_addr_o, cur_addr_o;
   logic [7:0] wr_data_o;
   int         err_count, comparisons, cycles;
   // Open-drain wire with pull-up: low while either party pulls
   assign sda_i = m_sda & !(sda_oe_o & !sda_o);
   eas_master i_mst (.clk_i(clk_sys_i), .sda_i(sda_i), .scl_o(scl), .sda_o(m_sda));
   eas_slave i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl),
      .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .chip_select_pin_high_i(pin_hi),
      .chip_select_pin_low_i(pin_lo), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
      .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .rd_req_o(rd_req_o),
      .cur_addr_o(cur_addr_o), .prog_busy_o(prog_busy_o));
   //////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // Address-only frame: start, slave byte, stop
   task automatic probe(input logic [7:0] b, input logic exp);
      i_mst.start_cond();
      i_mst.send_byte(b, ack);
      check("ack", 9'(exp), 9'(ack));
      i_mst.stop_cond();
   endtask : probe
   // One word taken by the consumer; an idle edge follows before the next call
   task automatic pop;
      wr_ready_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      wr_ready_i = 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask : pop
   // Every strap against every select field; page bit never matters
   task automatic test_select;
      for (int p = 0; p < 4; p++)
      begin
         {pin_hi, pin_lo} = 2'(p);
         for (int s = 0; s < 8; s++)
            probe({DEV_TYPE_CODE, 3'(s), 1'b0}, 2'(s >> 1) == 2'(p));
      end
      $display("select test done");
   endtask : test_select
   // Each single-bit error in the type field is refused
   task automatic test_type;
      for (int i = 0; i < 4; i++)
         probe({DEV_TYPE_CODE ^ 4'(1 << i), pin_hi, pin_lo, 2'b00}, 1'b0);
      $display("type test done");
   endtask : test_type
   // Direction bit decides the read request
   task automatic test_dir;
      for (int rw = 0; rw < 2; rw++)
      begin
         i_mst.start_cond();
         i_mst.send_byte({DEV_TYPE_CODE, pin_hi, pin_lo, 1'b0, 1'(rw)}, ack);
         check("ack dir", 9'h001, 9'(ack));
         check("rd_req", 9'(rw), 9'(rd_req_o));
         i_mst.stop_cond();
         check("busy dir", 9'h000, 9'(prog_busy_o));
      end
      $display("direction test done");
   endtask : test_dir
   // Narrow clock spike between bytes must not shift a bit
   task automatic test_spike;
      i_mst.start_cond();
      i_mst.send_byte({DEV_TYPE_CODE, pin_hi, pin_lo, 2'b00}, ack);
      check("ack spk", 9'h001, 9'(ack));
      i_mst.scl_spike();
      i_mst.send_byte(8'h5c, ack);
      check("ack spk addr", 9'h001, 9'(ack));
      check("spk addr", 9'h05c, cur_addr_o);
      i_mst.stop_cond();
      check("busy spk", 9'h000, 9'(prog_busy_o));
      $display("spike test done");
   endtask : test_spike
   // Stalled consumer: two words buffer, third refused, then program and drain
   task automatic test_write;
      i_mst.start_cond();
      i_mst.send_byte({DEV_TYPE_CODE, pin_hi, pin_lo, 2'b10}, ack);
      check("ack slv", 9'h001, 9'(ack));
      i_mst.send_byte(8'hfe, ack);
      check("ack addr", 9'h001, 9'(ack));
      check("cur_addr", 9'h1fe, cur_addr_o);
      i_mst.send_byte(8'h3c, ack);
      check("ack d0", 9'h001, 9'(ack));
      i_mst.send_byte(8'hc3, ack);
      check("ack d1", 9'h001, 9'(ack));
      i_mst.send_byte(8'h5a, ack);
      check("ack full", 9'h000, 9'(ack));
      i_mst.stop_cond();
      check("busy", 9'h001, 9'(prog_busy_o));
      check("addr0", 9'h1fe, wr_addr_o);
      check("data0", 9'h03c, 9'(wr_data_o));
      pop();
      check("addr1", 9'h1ff, wr_addr_o);
      check("data1", 9'h0c3, 9'(wr_data_o));
      pop();
      check("valid", 9'h000, 9'(wr_valid_o));
      probe({DEV_TYPE_CODE, pin_hi, pin_lo, 2'b00}, 1'b0);
      $display("write test done");
   endtask : test_write
   //////////////////////////////////////////////////////////
   initial
   begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard, well above the expected run length
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_count++;
         end_of_test();
      end
   end
   initial
   begin
      sys_rst_i = 1'b1;
      {pin_hi, pin_lo, wr_ready_i} = 3'b100;
      repeat (12) @(posedge clk_sys_i);
      #1;
      sys_rst_i = 1'b0;
      repeat (10) @(posedge clk_sys_i);
      #1;
      test_select();
      test_type();
      test_dir();
      test_spike();
      test_write();
      end_of_test();
   end
endmodule : eas_slave_bench
